// File: design/prescaler.sv
`timescale 1ns/1ps
`include "pwm_timer_defines.svh"

// divides the peripheral clock by two to the prescale index
module prescaler
(
	input  wire logic i_clock,
	input  wire logic i_reset,
	tick_if.source    ticks
);
	logic [15:0] div_count;
	logic [15:0] next_div_count;
	logic [15:0] div_mask;
	logic [4:0]  index;

	// index above the top value is held at the top
	always_comb
	begin
		index = (ticks.prescale_index > `PRESCALE_MAX) ?
			`PRESCALE_MAX : ticks.prescale_index;
		div_mask = 16'h0000;
		if (index != 5'h00)
		begin
			div_mask = 16'(17'h1_FFFF >> (5'h11 - index));
		end
		next_div_count = (ticks.clear || div_count == div_mask) ?
			16'h0000 : div_count + 16'h0001;
		// index 16 needs 65536 cycles: the mask is all ones
		ticks.tick = !ticks.clear && (div_count == div_mask);
	end

	always_ff @(posedge i_clock)
	begin
		if (i_reset)
			div_count <= 16'h0000;
		else
			div_count <= next_div_count;
	end
endmodule

// File: design/pwm_timer_counter.sv
// Operation
// - timer mode counts internal prescaled clock ticks
// - gating input exists on instance zero only
// - gating_off true ignores the gate input
// - pwm mode drives waveform when output enabled
// - output_invert inverts the pwm output
// - capture samples input each tick, instance zero
// - capture_invert inverts capture input before use
// - counter mode counts external input transitions
// - count_both_edges counts both edges, else rising
// - single shot: low, high at rise, low at fall
// - rise irq on rise, period irq on fall
// - single counter: rise irq, period irq, stop
// - repeat mode restarts cycle until stopped
// - repeat counter restarts from zero at fall
// - counter value readable at any time
// - counter mode only on instance zero
// - compare values 16 bits, 17 when wide
// - tick is clock over two to prescale index
// - gate polarity picks high gate with inversion
//
// Design decisions made here: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "pwm_timer_defines.svh"

module pwm_timer_counter
#(
	parameter int INSTANCE = 0
)
(
	input  wire logic        i_clock,
	input  wire logic        i_reset,
	input  wire logic [7:0]  i_address,
	input  wire logic [31:0] i_write_data,
	input  wire logic        i_write,
	input  wire logic        i_read,
	output logic      [31:0] o_read_data,
	input  wire logic        i_gate,
	input  wire logic        i_capture_input,
	input  wire logic        i_count_input,
	output logic             o_pwm_out,
	output logic             o_pwm_out_enable_n,
	output logic             o_rise_event_irq,
	output logic             o_period_end_irq
);
	localparam bit HAS_INPUTS = (INSTANCE == 0);

	// =========================================================
	// pin synchronisers
	// =========================================================
	logic [1:0] gate_sync;
	logic [1:0] cap_sync;
	logic [1:0] cnt_sync;
	logic       cnt_prev;
	logic       cap_prev;
	logic       capture_level;

	// two stages each; edge logic reads only the second stage
	always_ff @(posedge i_clock)
	begin
		if (i_reset)
		begin
			gate_sync <= 2'h0;
			cap_sync  <= 2'h0;
			cnt_sync  <= 2'h0;
			cnt_prev  <= 1'b0;
			cap_prev  <= 1'b0;
		end
		else
		begin
			gate_sync <= {gate_sync[0], i_gate};
			cap_sync  <= {cap_sync[0], i_capture_input};
			cnt_sync  <= {cnt_sync[0], i_count_input};
			cnt_prev  <= cnt_sync[1];
			cap_prev  <= capture_level;
		end
	end

	// =========================================================
	// software registers
	// =========================================================
	pwm_timer_pkg::mode_t mode;
	logic        repeat_mode;
	logic        wide;
	logic [15:0] config_reg;
	logic [16:0] rise_value;
	logic [16:0] fall_value;
	logic [16:0] count;
	logic [16:0] cap_rise;
	logic [16:0] cap_fall;
	logic        rise_flag;
	logic        period_flag;
	logic        output_level;
	logic [31:0] read_data;
	pwm_timer_pkg::run_state_t state;

	logic output_enable;
	logic output_invert;
	logic gating_off;
	logic gate_polarity_invert;
	logic capture_invert;
	logic count_both_edges;
	logic start_pulse;
	logic stop_pulse;
	logic [16:0] cmp_mask;

	// field unpacking of the config word
	always_comb
	begin
		output_enable        = config_reg[`CFG_OUT_EN];
		output_invert        = config_reg[`CFG_OUT_INV];
		gating_off           = config_reg[`CFG_GATE_OFF];
		gate_polarity_invert = config_reg[`CFG_GATE_POL];
		capture_invert       = config_reg[`CFG_CAP_INV];
		count_both_edges     = config_reg[`CFG_BOTH_EDGES];
		start_pulse = i_write && i_address == `OFS_CONTROL
			&& i_write_data[`CTL_START];
		stop_pulse  = i_write && i_address == `OFS_CONTROL
			&& i_write_data[`CTL_STOP];
		// narrow compare range unless wide mode chosen
		cmp_mask = wide ? 17'h1_FFFF : 17'h0_FFFF;
	end

	// =========================================================
	// tick generation and input conditioning
	// =========================================================
	tick_if ticks ();
	logic gated;
	logic count_edge;
	logic advance;

	prescaler u_prescaler
	(
		.i_clock (i_clock),
		.i_reset (i_reset),
		.ticks   (ticks)
	);

	// prescaler restarts with each start so the first tick is aligned
	always_comb
	begin
		ticks.prescale_index = config_reg[`CFG_PRE_HI:`CFG_PRE_LO];
		ticks.clear = start_pulse;
		capture_level = HAS_INPUTS &&
			(cap_sync[1] ^ capture_invert);
		// gate high with inversion, or gate low without
		gated = HAS_INPUTS && !gating_off &&
			(gate_polarity_invert ? gate_sync[1]
				: !gate_sync[1]);
		count_edge = (cnt_sync[1] && !cnt_prev) ||
			(count_both_edges && !cnt_sync[1] && cnt_prev);
		// counter mode tracks pin edges, others prescaled ticks
		if (mode == pwm_timer_pkg::MODE_COUNTER)
			advance = HAS_INPUTS && count_edge;
		else
			advance = ticks.tick && !gated;
	end

	// =========================================================
	// counter state machine
	// =========================================================
	pwm_timer_pkg::run_state_t next_state;
	logic [16:0] next_count;
	logic [16:0] count_inc;
	logic        next_output_level;
	logic        rise_hit;
	logic        fall_hit;
	logic [16:0] next_cap_rise;
	logic [16:0] next_cap_fall;

	always_comb
	begin
		next_state = state;
		next_count = count;
		next_output_level = output_level;
		next_cap_rise = cap_rise;
		next_cap_fall = cap_fall;
		count_inc = (count + 17'h0_0001) & cmp_mask;
		rise_hit = 1'b0;
		fall_hit = 1'b0;
		case (state)
			pwm_timer_pkg::ST_IDLE:
			begin
				if (start_pulse)
				begin
					next_state = pwm_timer_pkg::ST_LOW;
					next_count = 17'h0_0000;
					next_output_level = 1'b0;
				end
			end
			pwm_timer_pkg::ST_LOW, pwm_timer_pkg::ST_HIGH:
			begin
				if (advance)
				begin
					next_count = count_inc;
					// capture holds tick stamps of input edges
					if (capture_level && !cap_prev)
						next_cap_rise = count;
					if (!capture_level && cap_prev)
						next_cap_fall = count;
					if (state == pwm_timer_pkg::ST_LOW
						&& count_inc == (rise_value & cmp_mask))
					begin
						rise_hit = 1'b1;
						next_state = pwm_timer_pkg::ST_HIGH;
						next_output_level = 1'b1;
					end
					if (count_inc == (fall_value & cmp_mask))
					begin
						fall_hit = 1'b1;
						next_output_level = 1'b0;
						next_count = 17'h0_0000;
						if (repeat_mode)
							next_state = pwm_timer_pkg::ST_LOW;
						else
							next_state = pwm_timer_pkg::ST_IDLE;
					end
				end
				if (stop_pulse)
				begin
					next_state = pwm_timer_pkg::ST_IDLE;
					next_output_level = 1'b0;
				end
			end
			default:
			begin
				next_state = pwm_timer_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clock)
	begin
		if (i_reset)
		begin
			state        <= pwm_timer_pkg::ST_IDLE;
			count        <= 17'h0_0000;
			output_level <= 1'b0;
			cap_rise     <= 17'h0_0000;
			cap_fall     <= 17'h0_0000;
		end
		else
		begin
			state        <= next_state;
			count        <= next_count;
			output_level <= next_output_level;
			cap_rise     <= next_cap_rise;
			cap_fall     <= next_cap_fall;
		end
	end

	// =========================================================
	// register writes, flags and read port
	// =========================================================
	logic [15:0] next_config;
	logic [16:0] next_rise_value;
	logic [16:0] next_fall_value;
	pwm_timer_pkg::mode_t next_mode;
	logic        next_repeat;
	logic        next_wide;
	logic        next_rise_flag;
	logic        next_period_flag;
	logic [31:0] next_read_data;

	// writes to config are taken at any time; software orders them
	always_comb
	begin
		next_config = config_reg;
		next_rise_value = rise_value;
		next_fall_value = fall_value;
		next_mode = mode;
		next_repeat = repeat_mode;
		next_wide = wide;
		next_read_data = 32'h0000_0000;
		if (i_write && i_address == `OFS_CONFIG)
			next_config = i_write_data[15:0];
		if (i_write && i_address == `OFS_RISE_COUNT)
			next_rise_value = i_write_data[16:0];
		if (i_write && i_address == `OFS_FALL_COUNT)
			next_fall_value = i_write_data[16:0];
		if (start_pulse)
		begin
			next_repeat = i_write_data[`CTL_REPEAT];
			next_wide = i_write_data[`CTL_WIDE];
			next_mode = pwm_timer_pkg::mode_t'(
				i_write_data[`CTL_MODE_HI:`CTL_MODE_LO]);
			// modes needing pins fall back to timer elsewhere
			if (!HAS_INPUTS && next_mode[1])
				next_mode = pwm_timer_pkg::MODE_TIMER;
		end
		// flags are write-one-to-clear; a new event wins
		next_rise_flag = (rise_flag && !(i_write
			&& i_address == `OFS_STATUS
			&& i_write_data[`STS_RISE_FLAG]))
			|| (rise_hit && config_reg[`CFG_RISE_IE]);
		next_period_flag = (period_flag && !(i_write
			&& i_address == `OFS_STATUS
			&& i_write_data[`STS_PERIOD_FLAG]))
			|| (fall_hit && config_reg[`CFG_PERIOD_IE]);
		if (i_read)
		begin
			case (i_address)
				`OFS_CONTROL:    next_read_data = {26'h0, wide, mode,
					repeat_mode, 2'h0};
				`OFS_CONFIG:     next_read_data = {16'h0, config_reg};
				`OFS_RISE_COUNT: next_read_data = {15'h0, rise_value};
				`OFS_FALL_COUNT: next_read_data = {15'h0, fall_value};
				`OFS_COUNTER:    next_read_data = {15'h0, count};
				`OFS_STATUS:     next_read_data = {cap_fall[13:0],
					cap_rise[13:0], period_flag, rise_flag,
					output_level, state != pwm_timer_pkg::ST_IDLE};
				default:         next_read_data = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (i_reset)
		begin
			config_reg  <= `CONFIG_RESET;
			rise_value  <= 17'h0_0000;
			fall_value  <= 17'h0_0000;
			mode        <= pwm_timer_pkg::MODE_TIMER;
			repeat_mode <= 1'b0;
			wide        <= 1'b0;
			rise_flag   <= 1'b0;
			period_flag <= 1'b0;
			read_data   <= 32'h0000_0000;
		end
		else
		begin
			config_reg  <= next_config;
			rise_value  <= next_rise_value;
			fall_value  <= next_fall_value;
			mode        <= next_mode;
			repeat_mode <= next_repeat;
			wide        <= next_wide;
			rise_flag   <= next_rise_flag;
			period_flag <= next_period_flag;
			read_data   <= next_read_data;
		end
	end

	// =========================================================
	// outputs
	// =========================================================
	// pin driven only in pwm mode with output enabled
	always_comb
	begin
		o_read_data = read_data;
		o_pwm_out = output_level ^ output_invert;
		o_pwm_out_enable_n = !(mode == pwm_timer_pkg::MODE_PWM
			&& output_enable);
		o_rise_event_irq = rise_flag;
		o_period_end_irq = period_flag;
	end
endmodule

// File: design/pwm_timer_defines.svh
`ifndef PWM_TIMER_DEFINES_SVH
`define PWM_TIMER_DEFINES_SVH

// register offsets (word index == byte address / 4)
`define OFS_CONTROL      8'h00
`define OFS_CONFIG       8'h04
`define OFS_RISE_COUNT   8'h08
`define OFS_FALL_COUNT   8'h0C
`define OFS_COUNTER      8'h10
`define OFS_STATUS       8'h14

// control register fields
`define CTL_START        0
`define CTL_STOP         1
`define CTL_REPEAT       2
`define CTL_MODE_LO      3
`define CTL_MODE_HI      4
`define CTL_WIDE         5

// config register fields
`define CFG_OUT_EN       0
`define CFG_OUT_INV      1
`define CFG_GATE_OFF     2
`define CFG_GATE_POL     3
`define CFG_CAP_INV      4
`define CFG_BOTH_EDGES   5
`define CFG_RISE_IE      6
`define CFG_PERIOD_IE    7
`define CFG_PRE_LO       8
`define CFG_PRE_HI       12

// status register fields
`define STS_RUNNING      0
`define STS_OUTPUT       1
`define STS_RISE_FLAG    2
`define STS_PERIOD_FLAG  3
`define STS_CAPTURE      4

// reset values and sizes
`define CONFIG_RESET     16'h0004
`define PRESCALE_MAX     5'h10
`define COUNT_WIDTH      17

`endif

// File: design/pwm_timer_pkg.sv
package pwm_timer_pkg;

	// operating mode, selected by software
	typedef enum logic [1:0]
	{
		MODE_TIMER   = 2'h0,
		MODE_PWM     = 2'h1,
		MODE_CAPTURE = 2'h2,
		MODE_COUNTER = 2'h3
	} mode_t;

	// run state of the counter, one-hot
	typedef enum logic [2:0]
	{
		ST_IDLE = 3'h1,
		ST_LOW  = 3'h2,
		ST_HIGH = 3'h4
	} run_state_t;

endpackage

// File: design/tick_if.sv
`timescale 1ns/1ps
// tick source to counter core
interface tick_if;
	logic       tick;
	logic [4:0] prescale_index;
	logic       clear;

	modport source
	(
		input  prescale_index,
		input  clear,
		output tick
	);
	modport sink
	(
		output prescale_index,
		output clear,
		input  tick
	);
endinterface

// File: verif/pwm_timer_counter_bench.sv
`timescale 1ns/1ps
`include "pwm_timer_defines.svh"
// =====================================
// self-checking bench for timer zero
module pwm_timer_counter_bench;
	logic        clock = 1'b0;
	logic        reset = 1'b1;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [31:0] rdata;
	logic        gate, capture, count, pwm, pwm_en_n, rise_irq, period_irq;
	logic [31:0] q;
	int          err_count = 0;
	int          samples_checked = 0;

	// 50 MHz clock
	always #10 clock = ~clock;

	pwm_timer_far_side far
	(
		.i_clock(clock),
		.o_gate(gate),
		.o_capture(capture),
		.o_count(count)
	);
	pwm_timer_counter #(.INSTANCE(0)) dut
	(
		.i_clock(clock),
		.i_reset(reset),
		.i_address(addr),
		.i_write_data(wdata),
		.i_write(wr),
		.i_read(rd),
		.o_read_data(rdata),
		.i_gate(gate),
		.i_capture_input(capture),
		.i_count_input(count),
		.o_pwm_out(pwm),
		.o_pwm_out_enable_n(pwm_en_n),
		.o_rise_event_irq(rise_irq),
		.o_period_end_irq(period_irq)
	);

	// =====================================
	// bus and compare helpers
	task wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask
	// data stands only in the cycle after the strobe
	task rd_reg(input logic [7:0] a);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1 q = rdata;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			err_count++;
		end
	endtask
	// bounded wait for a flag, sampled after the edge settles
	task wait_irq(input bit per);
		int n;
		n = 0;
		while ((per ? period_irq : rise_irq) !== 1'b1 && n < 300)
		begin
			@(posedge clock);
			#1 n++;
		end
		// a flag that never comes is a mismatch
		if (n >= 300)
			err_count++;
	endtask
	task idle(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	// cycles the pin stays high, bounded
	task hold_high(output int n);
		n = 0;
		while (pwm === 1'b1 && n < 100)
		begin
			@(posedge clock);
			#1 n++;
		end
	endtask

	// =====================================
	// scenarios
	task t_reset;
		chk({28'h0, pwm, pwm_en_n, rise_irq, period_irq}, 32'h0000_0004);
		rd_reg(`OFS_CONFIG);
		chk(q, 32'h0000_0004);
		rd_reg(8'h20);
		chk(q, 32'h0000_0000);
	endtask
	task t_single_pwm;
		int n;
		wr_reg(`OFS_CONFIG, 32'h0000_00C5);
		wr_reg(`OFS_RISE_COUNT, 32'h0000_0003);
		wr_reg(`OFS_FALL_COUNT, 32'h0000_0006);
		wr_reg(`OFS_CONTROL, 32'h0000_0009);
		wait_irq(1'b0);
		chk({31'h0, pwm}, 32'h0000_0001);
		chk({31'h0, pwm_en_n}, 32'h0000_0000);
		hold_high(n);
		chk(n, 32'h0000_0003);
		chk({31'h0, period_irq}, 32'h0000_0001);
		rd_reg(`OFS_STATUS);
		chk(q & 32'h0000_000F, 32'h0000_000C);
		wr_reg(`OFS_STATUS, 32'h0000_000C);
		idle(1);
		chk({30'h0, rise_irq, period_irq}, 32'h0000_0000);
	endtask
	// tick every four cycles: high time is two ticks
	task t_prescale;
		int n;
		wr_reg(`OFS_CONFIG, 32'h0000_02C5);
		wr_reg(`OFS_RISE_COUNT, 32'h0000_0002);
		wr_reg(`OFS_FALL_COUNT, 32'h0000_0004);
		wr_reg(`OFS_CONTROL, 32'h0000_0009);
		wait_irq(1'b0);
		hold_high(n);
		chk(n, 32'h0000_0008);
		wr_reg(`OFS_STATUS, 32'h0000_000C);
	endtask
	task t_invert;
		wr_reg(`OFS_CONFIG, 32'h0000_0007);
		idle(2);
		chk({31'h0, pwm}, 32'h0000_0001);
	endtask
	// bit 16 of the compare values is dropped in narrow mode
	task t_repeat;
		int n;
		logic prev;
		wr_reg(`OFS_CONFIG, 32'h0000_0005);
		wr_reg(`OFS_RISE_COUNT, 32'h0001_0002);
		wr_reg(`OFS_FALL_COUNT, 32'h0001_0004);
		wr_reg(`OFS_CONTROL, 32'h0000_000D);
		n = 0;
		prev = 1'b0;
		repeat (40)
		begin
			@(posedge clock);
			#1;
			if (pwm === 1'b1 && prev === 1'b0)
				n++;
			prev = pwm;
		end
		chk(n, 32'h0000_000A);
		wr_reg(`OFS_CONTROL, 32'h0000_000A);
		idle(2);
		rd_reg(`OFS_STATUS);
		chk(q & 32'h0000_0003, 32'h0000_0000);
	endtask
	task t_counter;
		wr_reg(`OFS_CONFIG, 32'h0000_0004);
		wr_reg(`OFS_RISE_COUNT, 32'h0000_000A);
		wr_reg(`OFS_FALL_COUNT, 32'h0000_0014);
		wr_reg(`OFS_CONTROL, 32'h0000_0019);
		far.pulses(3);
		idle(6);
		rd_reg(`OFS_COUNTER);
		chk(q, 32'h0000_0003);
		wr_reg(`OFS_CONTROL, 32'h0000_001A);
		wr_reg(`OFS_CONFIG, 32'h0000_00A4);
		wr_reg(`OFS_CONTROL, 32'h0000_0019);
		far.pulses(3);
		idle(6);
		rd_reg(`OFS_COUNTER);
		chk(q, 32'h0000_0006);
		wr_reg(`OFS_CONTROL, 32'h0000_001A);
		wr_reg(`OFS_RISE_COUNT, 32'h0000_0002);
		wr_reg(`OFS_FALL_COUNT, 32'h0000_0004);
		wr_reg(`OFS_CONTROL, 32'h0000_0019);
		far.pulses(3);
		idle(6);
		chk({31'h0, period_irq}, 32'h0000_0001);
		rd_reg(`OFS_STATUS);
		chk(q & 32'h0000_0001, 32'h0000_0000);
		wr_reg(`OFS_STATUS, 32'h0000_000C);
		// repeat: six edges pass four, restart, two more
		wr_reg(`OFS_CONTROL, 32'h0000_001D);
		far.pulses(3);
		idle(6);
		rd_reg(`OFS_COUNTER);
		chk(q, 32'h0000_0002);
		wr_reg(`OFS_CONTROL, 32'h0000_001A);
		wr_reg(`OFS_STATUS, 32'h0000_000C);
	endtask
	task t_gate;
		far.set_gate(1'b1);
		wr_reg(`OFS_CONFIG, 32'h0000_0008);
		wr_reg(`OFS_RISE_COUNT, 32'h0000_0064);
		wr_reg(`OFS_FALL_COUNT, 32'h0000_00C8);
		wr_reg(`OFS_CONTROL, 32'h0000_0001);
		idle(10);
		rd_reg(`OFS_COUNTER);
		chk(q, 32'h0000_0000);
		far.set_gate(1'b0);
		idle(10);
		rd_reg(`OFS_COUNTER);
		chk({31'h0, q != 32'h0000_0000}, 32'h0000_0001);
		wr_reg(`OFS_CONTROL, 32'h0000_0002);
		// plain polarity: a low gate holds the count
		wr_reg(`OFS_CONFIG, 32'h0000_0000);
		wr_reg(`OFS_CONTROL, 32'h0000_0001);
		idle(10);
		rd_reg(`OFS_COUNTER);
		chk(q, 32'h0000_0000);
		wr_reg(`OFS_CONTROL, 32'h0000_0002);
	endtask
	// stamp difference gives the pulse width in ticks
	task t_capture;
		wr_reg(`OFS_CONFIG, 32'h0000_0004);
		wr_reg(`OFS_CONTROL, 32'h0000_0011);
		far.cap_pulse(5);
		rd_reg(`OFS_STATUS);
		chk({18'h0, 14'(q[31:18] - q[17:4])}, 32'h0000_0005);
		wr_reg(`OFS_CONTROL, 32'h0000_0012);
		// inverted: the stamps swap roles
		wr_reg(`OFS_CONFIG, 32'h0000_0014);
		wr_reg(`OFS_CONTROL, 32'h0000_0011);
		far.cap_pulse(3);
		rd_reg(`OFS_STATUS);
		chk({18'h0, 14'(q[17:4] - q[31:18])}, 32'h0000_0003);
		wr_reg(`OFS_CONTROL, 32'h0000_0012);
	endtask

	// =====================================
	// closing
	task print_verdict;
		$display("checks=%0d errors=%0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// main sequence after eight reset cycles
	initial
	begin
		repeat (8) @(posedge clock);
		reset <= 1'b0;
		idle(1);
		t_reset();
		t_single_pwm();
		t_prescale();
		t_invert();
		t_repeat();
		t_counter();
		t_gate();
		t_capture();
		print_verdict();
	end
	// watchdog, far beyond the few hundred cycles needed
	initial
	begin
		#400000;
		err_count++;
		print_verdict();
	end
endmodule

// File: verif/pwm_timer_counter_monitor.sv
`timescale 1ns/1ps
`include "pwm_timer_defines.svh"
// =====================================
// port checker for the timer
module pwm_timer_counter_monitor
(
	input wire logic        i_clock,
	input wire logic        i_reset,
	input wire logic [7:0]  i_address,
	input wire logic [31:0] i_write_data,
	input wire logic        i_write,
	input wire logic        i_read,
	input wire logic [31:0] o_read_data,
	input wire logic        i_gate,
	input wire logic        i_capture_input,
	input wire logic        i_count_input,
	input wire logic        o_pwm_out,
	input wire logic        o_pwm_out_enable_n,
	input wire logic        o_rise_event_irq,
	input wire logic        o_period_end_irq
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_reset);

	a_reset_quiet: assert property (disable iff (1'b0)
		i_reset |=> !o_pwm_out && o_pwm_out_enable_n && !o_rise_event_irq
		&& !o_period_end_irq && o_read_data == 32'h0000_0000)
		else $error("outputs not quiet after reset");
	a_read_idle_zero: assert property (
		!$past(i_read) |-> o_read_data == 32'h0000_0000)
		else $error("read data outside read cycle");
	a_read_unmapped: assert property (
		$past(i_read) && $past(i_address) == 8'h20
		|-> o_read_data == 32'h0000_0000)
		else $error("unmapped read not zero");
	a_rise_on_edge: assert property (
		$rose(o_rise_event_irq) |-> $changed(o_pwm_out))
		else $error("rise flag without output rise");
	a_period_on_edge: assert property (
		$rose(o_period_end_irq) |-> $changed(o_pwm_out))
		else $error("period flag without output fall");
	a_enable_by_write: assert property (
		$changed(o_pwm_out_enable_n) |-> $past(i_write) || $past(i_write, 2))
		else $error("pin enable moved without a write");
	a_rise_flag_sticky: assert property (
		$fell(o_rise_event_irq)
		|-> $past(i_write) && $past(i_address) == `OFS_STATUS)
		else $error("rise flag dropped on its own");
	a_period_flag_sticky: assert property (
		$fell(o_period_end_irq)
		|-> $past(i_write) && $past(i_address) == `OFS_STATUS)
		else $error("period flag dropped on its own");
endmodule

bind pwm_timer_counter pwm_timer_counter_monitor mon
(
	.i_clock(i_clock),
	.i_reset(i_reset),
	.i_address(i_address),
	.i_write_data(i_write_data),
	.i_write(i_write),
	.i_read(i_read),
	.o_read_data(o_read_data),
	.i_gate(i_gate),
	.i_capture_input(i_capture_input),
	.i_count_input(i_count_input),
	.o_pwm_out(o_pwm_out),
	.o_pwm_out_enable_n(o_pwm_out_enable_n),
	.o_rise_event_irq(o_rise_event_irq),
	.o_period_end_irq(o_period_end_irq)
);

// File: verif/pwm_timer_far_side.sv
`timescale 1ns/1ps
// =====================================
// pins beside timer zero: gate, capture and count
module pwm_timer_far_side
(
	input  wire logic i_clock,
	output logic      o_gate,
	output logic      o_capture,
	output logic      o_count
);
	// idle pin levels
	initial
	begin
		o_gate = 1'b0;
		o_capture = 1'b0;
		o_count = 1'b0;
	end
	// whole pulses, slow so the two-flop sync sees each level
	task pulses(input int n);
		repeat (n)
		begin
			repeat (4) @(posedge i_clock);
			o_count <= 1'b1;
			repeat (4) @(posedge i_clock);
			o_count <= 1'b0;
		end
	endtask
	// gate level held until changed again
	task set_gate(input logic v);
		@(posedge i_clock);
		o_gate <= v;
	endtask
	// one high pulse of w cycles, then time for the sync to settle
	task cap_pulse(input int w);
		@(posedge i_clock);
		o_capture <= 1'b1;
		repeat (w) @(posedge i_clock);
		o_capture <= 1'b0;
		repeat (4) @(posedge i_clock);
	endtask
endmodule
